// *** logic/lcd_control_frame_clock.sv ***
// LCD main control register, AXI4-Lite slave and frame clock generation.
`timescale 1ns/100ps

module lcd_control_frame_clock (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [lcd_frame_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [lcd_frame_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sub_clk_tick,
    input wire logic sys_clk_stopped,
    input wire logic standby_mode,
    output logic drive_supply_on,
    output logic display_running,
    output logic show_memory_out,
    output logic op_clk_tick,
    output logic frame_tick,
    output logic [1:0] duty_sel_out
);

    // ------------------------------------------------------------------
    // Register bus state
    // ------------------------------------------------------------------
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [lcd_frame_pkg::ADDR_W-1:0] waddr_r, waddr_nxt;
    logic [7:0] wbyte_r, wbyte_nxt;
    logic wlane_r, wlane_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [7:0] main_r, main_nxt;
    logic [1:0] duty_r, duty_nxt;
    logic aw_take, w_take, do_write, wr_main, wr_duty, wr_ok;
    logic [lcd_frame_pkg::ADDR_W-1:0] wr_addr;

    // ------------------------------------------------------------------
    // Frame clock state
    // ------------------------------------------------------------------
    logic [7:0] sys_div_r, sys_div_nxt;
    logic [1:0] sub_div_r, sub_div_nxt;
    logic [7:0] frame_cnt_r, frame_cnt_nxt;
    logic [3:0] applied_sel_r, applied_sel_nxt;
    logic op_tick_r, op_tick_nxt, frame_tick_r, frame_tick_nxt;
    logic supply_r, supply_nxt, running_r, running_nxt, show_r, show_nxt;
    logic [1:0] duty_out_r, duty_out_nxt;
    logic [7:0] sys_mask, frame_last;
    logic sys_tick, sub_tick, run, op_tick, frame_wrap;

    // Write channel: address and data are held independently, the response follows both.
    always_comb begin
        aw_take = s_axi_awvalid & awready_r;
        w_take = s_axi_wvalid & wready_r;
        aw_held_nxt = aw_held_r | aw_take;
        w_held_nxt = w_held_r | w_take;
        waddr_nxt = aw_take ? s_axi_awaddr : waddr_r;
        wbyte_nxt = w_take ? s_axi_wdata[7:0] : wbyte_r;
        wlane_nxt = w_take ? s_axi_wstrb[0] : wlane_r;
        bvalid_nxt = bvalid_r & ~s_axi_bready;
        bresp_nxt = bresp_r;
        do_write = aw_held_nxt & w_held_nxt & ~bvalid_r;
        wr_addr = waddr_nxt;
        wr_ok = (wr_addr[1:0] == lcd_frame_pkg::ADDR_ALIGN_OK) &&
                (wr_addr == lcd_frame_pkg::ADDR_MAIN_CONTROL || wr_addr == lcd_frame_pkg::ADDR_DUTY_CONTROL ||
                 wr_addr == lcd_frame_pkg::ADDR_FRAME_STATUS);
        wr_main = do_write & wlane_nxt & (wr_addr == lcd_frame_pkg::ADDR_MAIN_CONTROL);
        wr_duty = do_write & wlane_nxt & (wr_addr == lcd_frame_pkg::ADDR_DUTY_CONTROL);
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_ok ? lcd_frame_pkg::RESP_OKAY : lcd_frame_pkg::RESP_SLVERR;
        end
        awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
        wready_nxt = ~w_held_nxt & ~bvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= lcd_frame_pkg::ADDR_MAIN_CONTROL;
            wbyte_r <= 8'h00;
            wlane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= lcd_frame_pkg::RESP_OKAY;
        end else begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            waddr_r <= waddr_nxt;
            wbyte_r <= wbyte_nxt;
            wlane_r <= wlane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // Control registers change only by a bus write, so halting keeps every setting.
    // halting keeps settings
    always_comb begin
        main_nxt = main_r;
        duty_nxt = duty_r;
        if (wr_main) begin
            main_nxt = wbyte_nxt | lcd_frame_pkg::MAIN_FIXED_MASK;
        end
        if (wr_duty) begin
            duty_nxt = {wbyte_nxt[lcd_frame_pkg::BIT_DUTY_SEL_1], wbyte_nxt[lcd_frame_pkg::BIT_DUTY_SEL_0]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_r <= lcd_frame_pkg::MAIN_CONTROL_RESET;
            duty_r <= lcd_frame_pkg::DUTY_RESET;
        end else begin
            main_r <= main_nxt;
            duty_r <= duty_nxt;
        end
    end

    // Read channel: one cycle from address to data; unmapped or unaligned reads answer SLVERR.
    always_comb begin
        rvalid_nxt = rvalid_r & ~s_axi_rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = lcd_frame_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            if (s_axi_araddr == lcd_frame_pkg::ADDR_MAIN_CONTROL) begin
                rdata_nxt[7:0] = main_r;
            end else if (s_axi_araddr == lcd_frame_pkg::ADDR_DUTY_CONTROL) begin
                rdata_nxt[lcd_frame_pkg::BIT_DUTY_SEL_1] = duty_r[1];
                rdata_nxt[lcd_frame_pkg::BIT_DUTY_SEL_0] = duty_r[0];
            end else if (s_axi_araddr == lcd_frame_pkg::ADDR_FRAME_STATUS) begin
                rdata_nxt[lcd_frame_pkg::BIT_STAT_RUNNING] = running_r;
                rdata_nxt[lcd_frame_pkg::BIT_STAT_SUPPLY] = supply_r;
                rdata_nxt[lcd_frame_pkg::LSB_STAT_APPLIED_SEL +: 4] = applied_sel_r;
            end else begin
                rresp_nxt = lcd_frame_pkg::RESP_SLVERR;
            end
        end
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= lcd_frame_pkg::RESP_OKAY;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Operating clock and frame generation
    // ------------------------------------------------------------------

    // Prescalers run on the applied selection, which only moves at frame ends or while halted, so a select write never shortens a running frame.
    always_comb begin
        sys_mask = 8'((lcd_frame_pkg::SYS_MASK_SEED << applied_sel_r[2:0]) - lcd_frame_pkg::SYS_MASK_ONE);
        sys_tick = ((sys_div_r & sys_mask) == sys_mask);
        if (applied_sel_r[1:0] == lcd_frame_pkg::SUB_DIV_BY_ONE) begin
            sub_tick = sub_clk_tick;
        end else if (applied_sel_r[1:0] == lcd_frame_pkg::SUB_DIV_BY_TWO) begin
            sub_tick = sub_clk_tick & sub_div_r[0];
        end else begin
            sub_tick = sub_clk_tick & (&sub_div_r);
        end
        run = main_r[lcd_frame_pkg::BIT_DISPLAY_ACTIVATE] & ~standby_mode &
              ~(applied_sel_r[lcd_frame_pkg::BIT_FRAME_CLK_SEL_3] & sys_clk_stopped);
        op_tick = run & (applied_sel_r[lcd_frame_pkg::BIT_FRAME_CLK_SEL_3] ? sys_tick : sub_tick);
        frame_last = (duty_r == lcd_frame_pkg::DUTY_ONE_THIRD) ? lcd_frame_pkg::FRAME_LAST_THIRD :
                     lcd_frame_pkg::FRAME_LAST_NORMAL;
        frame_wrap = op_tick & (frame_cnt_r >= frame_last);
        sys_div_nxt = run ? sys_div_r + 8'h01 : 8'h00;
        sub_div_nxt = (run && sub_clk_tick) ? sub_div_r + 2'h1 : (run ? sub_div_r : 2'h0);
        frame_cnt_nxt = frame_cnt_r;
        applied_sel_nxt = applied_sel_r;
        if (!run) begin
            frame_cnt_nxt = 8'h00;
            applied_sel_nxt = main_r[3:0];
        end else if (frame_wrap) begin
            frame_cnt_nxt = 8'h00;
            applied_sel_nxt = main_r[3:0];
        end else if (op_tick) begin
            frame_cnt_nxt = frame_cnt_r + 8'h01;
        end
        op_tick_nxt = op_tick;
        frame_tick_nxt = frame_wrap;
        supply_nxt = main_r[lcd_frame_pkg::BIT_DRIVE_SUPPLY_CONNECT] &
                     main_r[lcd_frame_pkg::BIT_DISPLAY_ACTIVATE] & ~standby_mode;
        running_nxt = run;
        show_nxt = run & main_r[lcd_frame_pkg::BIT_SHOW_MEMORY];
        duty_out_nxt = duty_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_div_r <= 8'h00;
            sub_div_r <= 2'h0;
            frame_cnt_r <= 8'h00;
            applied_sel_r <= lcd_frame_pkg::FRAME_SEL_RESET;
            op_tick_r <= 1'b0;
            frame_tick_r <= 1'b0;
            supply_r <= 1'b0;
            running_r <= 1'b0;
            show_r <= 1'b0;
            duty_out_r <= lcd_frame_pkg::DUTY_RESET;
        end else begin
            sys_div_r <= sys_div_nxt;
            sub_div_r <= sub_div_nxt;
            frame_cnt_r <= frame_cnt_nxt;
            applied_sel_r <= applied_sel_nxt;
            op_tick_r <= op_tick_nxt;
            frame_tick_r <= frame_tick_nxt;
            supply_r <= supply_nxt;
            running_r <= running_nxt;
            show_r <= show_nxt;
            duty_out_r <= duty_out_nxt;
        end
    end

    // Every output leaves straight from a flip-flop.
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign drive_supply_on = supply_r;
    assign display_running = running_r;
    assign show_memory_out = show_r;
    assign op_clk_tick = op_tick_r;
    assign frame_tick = frame_tick_r;
    assign duty_sel_out = duty_out_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_frame_end;
        frame_tick_r;
    endsequence

    sequence s_third_duty_before;
        $past(duty_r) == lcd_frame_pkg::DUTY_ONE_THIRD;
    endsequence

    a_fixed_bit_one: assert property (main_r[lcd_frame_pkg::BIT_FIXED_ONE])
        else $error("Fixed control bit is not one.");
    a_supply_gate: assert property (supply_r |-> $past(main_r[6] && main_r[5] && !standby_mode))
        else $error("Drive supply on without connect, activate and no standby.");
    a_halt_stops: assert property (!main_r[5] |=> !op_tick_r && !running_r)
        else $error("Operation continued while deactivated.");
    a_regs_kept: assert property (!do_write |=> $stable(main_r) && $stable(duty_r))
        else $error("Control register changed without a write.");
    a_show_memory: assert property (show_r |-> $past(main_r[4] && main_r[5]))
        else $error("Memory shown while show bit is zero.");
    a_sub_halved: assert property (op_tick_r && $past(applied_sel_r) == 4'h1 |-> $past(sub_div_r[0] && sub_clk_tick))
        else $error("Sub-clock halving produced a wrong tick.");
    a_sys_divide: assert property (op_tick_r && $past(applied_sel_r[3]) |-> $past((sys_div_r & sys_mask) == sys_mask))
        else $error("System clock divider produced a wrong tick.");
    a_sys_stopped: assert property (applied_sel_r[3] && sys_clk_stopped |=> !op_tick_r)
        else $error("Tick produced while system clock is stopped.");
    a_third_frame: assert property (s_frame_end and s_third_duty_before |-> $past(frame_cnt_r) >= 8'hBF)
        else $error("Third-duty frame ended at the wrong count.");
    a_duty_follow: assert property ($changed(duty_r) |=> duty_out_r == $past(duty_r))
        else $error("Duty output did not follow the duty register.");
    a_sel_boundary: assert property ($changed(applied_sel_r) |-> $past(frame_wrap || !run))
        else $error("Clock selection changed inside a frame.");

endmodule

// *** logic/lcd_frame_pkg.sv ***
// Constants shared by the LCD control and frame clock block: register map, fields, reset values and dividers.
package lcd_frame_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_MAIN_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_DUTY_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_FRAME_STATUS = 4'h8;
    localparam logic [1:0] ADDR_ALIGN_OK = 2'h0;

    // ------------------------------------------------------------------
    // Main control fields
    // ------------------------------------------------------------------
    localparam int BIT_FIXED_ONE = 7;
    localparam int BIT_DRIVE_SUPPLY_CONNECT = 6;
    localparam int BIT_DISPLAY_ACTIVATE = 5;
    localparam int BIT_SHOW_MEMORY = 4;
    localparam int BIT_FRAME_CLK_SEL_3 = 3;
    localparam logic [7:0] MAIN_CONTROL_RESET = 8'h80;
    localparam logic [7:0] MAIN_FIXED_MASK = 8'h80;

    // ------------------------------------------------------------------
    // Duty control fields, duty_sel_1 and duty_sel_0 at bits 7:6
    // ------------------------------------------------------------------
    localparam int BIT_DUTY_SEL_1 = 7;
    localparam int BIT_DUTY_SEL_0 = 6;
    localparam logic [1:0] DUTY_RESET = 2'h0;
    localparam logic [1:0] DUTY_ONE_THIRD = 2'h2;

    // ------------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------------
    localparam int BIT_STAT_RUNNING = 0;
    localparam int BIT_STAT_SUPPLY = 1;
    localparam int LSB_STAT_APPLIED_SEL = 4;

    // ------------------------------------------------------------------
    // Dividers: last frame count in operating clock ticks, one below the frame length
    // ------------------------------------------------------------------
    localparam logic [3:0] FRAME_SEL_RESET = 4'h0;
    localparam logic [7:0] FRAME_LAST_NORMAL = 8'hFF;
    localparam logic [7:0] FRAME_LAST_THIRD = 8'hBF;
    localparam logic [1:0] SUB_DIV_BY_ONE = 2'h0;
    localparam logic [1:0] SUB_DIV_BY_TWO = 2'h1;
    localparam logic [15:0] SYS_MASK_SEED = 16'h0002;
    localparam logic [15:0] SYS_MASK_ONE = 16'h0001;

    // ------------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** tb/lcd_panel_model.sv ***
// Far side of the block: a free-running watch-crystal tick source and a panel that times the drive pulses.
`timescale 1ns/100ps
module lcd_panel_model #(
    parameter int SUB_PERIOD = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic op_clk_tick,
    input wire logic frame_tick,
    output logic sub_clk_tick,
    output int op_gap,
    output int frame_gap,
    output int op_count,
    output int frame_count
);
    int sub_cnt = 0;
    int op_age = 0;
    int fr_age = 0;

    initial sub_clk_tick = 1'b0;

    // The watch crystal keeps running in every power mode, so its ticks never pause.
    always @(posedge aclk) begin
        sub_cnt <= (sub_cnt >= SUB_PERIOD - 1) ? 0 : sub_cnt + 1;
        sub_clk_tick <= (sub_cnt == SUB_PERIOD - 1);
    end

    // Gaps count aclk cycles between consecutive pulses; the counts let the bench wait for fresh pulses.
    always @(posedge aclk) begin
        if (!aresetn) begin
            op_age <= 0;
            fr_age <= 0;
        end else begin
            op_age <= op_clk_tick ? 1 : op_age + 1;
            fr_age <= frame_tick ? 1 : fr_age + 1;
            if (op_clk_tick) begin
                op_gap <= op_age;
                op_count <= op_count + 1;
            end
            if (frame_tick) begin
                frame_gap <= fr_age;
                frame_count <= frame_count + 1;
            end
        end
    end
endmodule

// *** tb/lcd_control_frame_clock_test.sv ***
// Self-checking testbench for the LCD control register and frame clock block.
`timescale 1ns/100ps
module lcd_control_frame_clock_test;
    localparam int SUB_P = 6;
    localparam int LIMIT = 60000;
    localparam logic [3:0] A_MAIN = lcd_frame_pkg::ADDR_MAIN_CONTROL;
    localparam logic [3:0] A_DUTY = lcd_frame_pkg::ADDR_DUTY_CONTROL;
    localparam logic [3:0] A_STAT = lcd_frame_pkg::ADDR_FRAME_STATUS;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [lcd_frame_pkg::ADDR_W-1:0] s_axi_awaddr = 4'h0;
    logic [lcd_frame_pkg::ADDR_W-1:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic sys_clk_stopped = 1'b0;
    logic standby_mode = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, duty_sel_out, wr_resp, rd_resp;
    logic [31:0] s_axi_rdata, rd_data;
    logic sub_clk_tick, drive_supply_on, display_running, show_memory_out, op_clk_tick, frame_tick;
    int op_gap, frame_gap, op_count, frame_count;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;

    // ------------------------------------------------------------------
    // Design, far side, clock and hang guard
    // ------------------------------------------------------------------
    lcd_control_frame_clock dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sub_clk_tick, .sys_clk_stopped, .standby_mode, .drive_supply_on, .display_running,
        .show_memory_out, .op_clk_tick, .frame_tick, .duty_sel_out
    );

    lcd_panel_model #(.SUB_PERIOD(SUB_P)) panel (
        .aclk, .aresetn, .op_clk_tick, .frame_tick, .sub_clk_tick, .op_gap, .frame_gap, .op_count, .frame_count
    );

    always #20 aclk = ~aclk;

    // A stuck handshake would otherwise hang the run, so the cycle ceiling forces the verdict.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask

    // Write and address are offered together; each is released at its own taking edge.
    task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic waitn(input bit fr, input int n);
        int c0;
        c0 = fr ? frame_count : op_count;
        while ((fr ? frame_count : op_count) < c0 + n) @(posedge aclk);
    endtask

    function automatic logic [7:0] ctl(input logic drive_supply_connect, input logic act, input logic show_memory, input logic [3:0] sel);
        return {1'b0, drive_supply_connect, act, show_memory, sel};
    endfunction

    function automatic int exp_gap(input logic [3:0] sel);
        if (sel[3]) return 2 << sel[2:0];
        return SUB_P * (sel[1] ? 4 : (sel[0] ? 2 : 1));
    endfunction

    // Halting first makes a new select apply at once instead of waiting for a frame end.
    task automatic setsel(input logic [3:0] sel);
        axw(A_MAIN, ctl(1'b0, 1'b0, 1'b0, sel));
        axw(A_MAIN, ctl(1'b0, 1'b1, 1'b0, sel));
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int c;
        logic [7:0] d;
        void'($urandom(78));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axr(A_MAIN);
        chk(rd_data, 32'h80);
        axr(A_DUTY);
        chk(rd_data, 32'h0);
        chk(32'(drive_supply_on), 32'h0);
        $display("test reset done");
        repeat (12) begin
            d = 8'($urandom);
            axw(A_MAIN, d);
            axr(A_MAIN);
            chk(rd_data, {24'h0, d | 8'h80});
        end
        axw(A_MAIN, ~d, 4'h0);
        chk(32'(wr_resp), 32'(lcd_frame_pkg::RESP_OKAY));
        axr(A_MAIN);
        chk(rd_data, {24'h0, d | 8'h80});
        axw(4'hC, d);
        chk(32'(wr_resp), 32'(lcd_frame_pkg::RESP_SLVERR));
        axr(4'hC);
        chk({rd_data[29:0], rd_resp}, 32'(lcd_frame_pkg::RESP_SLVERR));
        $display("test register access done");
        for (int i = 0; i < 16; i++) begin
            axw(A_MAIN, ctl(i[0], i[1], i[2], 4'h0));
            standby_mode <= i[3];
            repeat (3) @(posedge aclk);
            chk(32'(drive_supply_on), 32'(i[0] & i[1] & !i[3]));
            chk(32'(display_running), 32'(i[1] & !i[3]));
            if (i[1] && !i[3]) chk(32'(show_memory_out), 32'(i[2]));
            axr(A_MAIN);
            chk(rd_data, 32'(ctl(i[0], i[1], i[2], 4'h0) | 8'h80));
        end
        standby_mode <= 1'b0;
        $display("test supply and activate done");
        for (int s = 0; s < 16; s++) begin
            setsel(4'(s));
            waitn(1'b0, 3);
            chk(32'(op_gap), 32'(exp_gap(4'(s))));
        end
        $display("test clock select done");
        setsel(4'h8);
        for (int k = 3; k >= 0; k--) begin
            axw(A_DUTY, {2'(k), 6'h0});
            // The duty output leaves its flop one edge after the write lands, so look once it has settled.
            @(negedge aclk);
            chk(32'(duty_sel_out), 32'(k));
            waitn(1'b1, 2);
            chk(32'(frame_gap), (k == 2) ? 32'd384 : 32'd512);
        end
        $display("test duty and frame done");
        waitn(1'b1, 1);
        repeat (40) @(posedge aclk);
        // software rewrites select
        // The system clock is taken to double back from medium speed, so the divider doubles too.
        axw(A_MAIN, ctl(1'b0, 1'b1, 1'b0, 4'h9));
        axr(A_STAT);
        chk(rd_data, 32'h81);
        waitn(1'b1, 1);
        repeat (3) @(posedge aclk);
        axr(A_STAT);
        chk(rd_data, 32'h91);
        waitn(1'b0, 3);
        chk(32'(op_gap), 32'd4);
        waitn(1'b1, 1);
        chk(32'(frame_gap), 32'(256 * exp_gap(4'h9)));
        $display("test frame boundary done");
        sys_clk_stopped <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'(display_running), 32'h0);
        c = op_count;
        repeat (40) @(posedge aclk);
        chk(32'(op_count), 32'(c));
        // Software moves to the divided sub-clock before relying on the display in low power.
        axw(A_MAIN, ctl(1'b1, 1'b1, 1'b0, 4'h2));
        waitn(1'b0, 3);
        chk(32'(op_gap), 32'(4 * SUB_P));
        chk(32'({display_running, drive_supply_on}), 32'h3);
        sys_clk_stopped <= 1'b0;
        $display("test stopped system clock done");
        conclude();
    end
endmodule
